// File: src/dss_dev_end.sv
// device end: dual-select serial slave, config registers, byte fifo and bit serializer
//
// Notes on behaviour
// - config select wins over data select
// - host uses mode 0, clock idles low
// - host holds select low during transfer
// - sdo released whenever not addressed
// - sdo released line keeps last level
// - host selects eight clocks per byte
// - sdi sampled on rising clock edge
// - sdo changes on falling clock edge
// - most significant bit first both ways
// - config clock at most 6 MHz
// - data clock at most 1 MHz
// - register writes commit at select release
// - write burst alternates address and value
// - read burst alternates address and value
// - fifo push on data select release
// - host should release select between reads
// - data port only in buffered, packet modes
// - fifo is one byte wide
// - serializer sends fifo bytes at bit rate
// - serializer packs received bits into fifo
// - reset defaults, kept through sleep
// - continuous mode bypasses fifo and port
`timescale 1ns/100ps
module dss_dev_end #(
    parameter int FIFO_DEPTH = 64,
    parameter int BIT_BASE   = dss_pkg::BIT_BASE_CYC
) (
    // core clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // serial link
    dss_link_if.dev         link,
    // continuous mode bypass
    input  wire logic       cont_tx_bit,
    output logic            cont_rx_bit,
    // modulator and demodulator side
    input  wire logic       demod_bit,
    input  wire logic       demod_valid,
    output logic            mod_bit,
    // fifo status
    output logic [$clog2(FIFO_DEPTH):0] fifo_level,
    output logic            fifo_empty,
    output logic            fifo_full
);

    localparam int AW = $clog2(FIFO_DEPTH);

    // ****************************************************************
    // state types
    // ****************************************************************
    typedef struct packed {
        logic [2:0] cnt;
        logic [6:0] shin;
        logic       phase;
        logic [4:0] addr;
    } dss_lrx_t;

    typedef struct packed {
        logic [7:0] byte_v;
        logic       was_addr;
        logic       is_cfg;
        logic       tgl;
    } dss_lhx_t;

    typedef struct packed {
        logic       started;
        logic       bit_v;
        logic [6:0] sh;
    } dss_ltx_t;

    typedef struct packed {
        dss_pkg::dss_regs_t          cfg;
        dss_pkg::dss_regs_t          stage;
        logic [dss_pkg::NUM_REGS-1:0] smask;
        logic [4:0]                  waddr;
        logic                        wen;
        logic [7:0]                  pend;
        logic                        pend_v;
        logic [2:0]                  s_cfg;
        logic [2:0]                  s_dat;
        logic [2:0]                  s_tgl;
        logic [1:0]                  s_ctx;
        logic [FIFO_DEPTH-1:0][7:0]  mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 level;
        logic                        empty;
        logic                        full;
        logic [7:0]                  ser_sh;
        logic [2:0]                  ser_n;
        logic [15:0]                 tick_cnt;
        logic                        mod_bit;
        logic                        cont_rx;
    } dss_core_t;

    localparam dss_core_t CORE_RST = '{cfg: dss_pkg::dss_cfg_reset(), empty: 1'b1, default: '0};

    dss_lrx_t  rx_q,   rx_d;
    dss_lhx_t  hx_q,   hx_d;
    dss_ltx_t  tx_q,   tx_d;
    dss_core_t c_q,    c_d;

    // ****************************************************************
    // mode decode and selection
    // ****************************************************************
    logic [2:0] chip_mode;
    logic       data_on;
    logic       rx_mode;
    logic       tx_mode;
    logic       sel_cfg;
    logic       sel_dat;
    logic       frame_rst_n;
    logic [7:0] head;
    logic [7:0] src;

    assign chip_mode = c_q.cfg[dss_pkg::REG_CHIP_MODE][dss_pkg::CHIP_MODE_LSB +: 3];
    assign data_on   = c_q.cfg[dss_pkg::REG_DATA_MODE][dss_pkg::DATA_MODE_LSB +: 2] != dss_pkg::DM_CONT;
    assign rx_mode   = chip_mode == dss_pkg::CM_RX;
    assign tx_mode   = chip_mode == dss_pkg::CM_TX;
    assign sel_cfg   = ~link.config_select_n;
    assign sel_dat   = link.config_select_n & ~link.data_select_n & data_on;
    // the link clock stands still between frames, so the frame state is
    // cleared by the selects themselves rather than by a clock edge
    assign frame_rst_n = rst_n & (sel_cfg | sel_dat);
    assign head        = c_q.mem[c_q.rp];
    // config registers only move while the link is idle; the fifo head moves between bytes
    // and also on a serializer pop or a serializer push into an empty fifo, yet the link side reads both directly
    assign src         = sel_cfg ? c_q.cfg[rx_q.addr] : head;

    // ****************************************************************
    // link side: receive on rising edge
    // ****************************************************************
    always_comb begin
        rx_d      = rx_q;
        rx_d.cnt  = rx_q.cnt + 3'h1;
        rx_d.shin = {rx_q.shin[5:0], link.sdi};
        if (rx_q.cnt == 3'h7) begin
            if (sel_cfg) begin
                rx_d.phase = ~rx_q.phase;
                if (!rx_q.phase) begin
                    rx_d.addr = {rx_q.shin[3:0], link.sdi};
                end
            end
        end
    end

    always_comb begin
        hx_d = hx_q;
        if (rx_q.cnt == 3'h7 && (sel_cfg || sel_dat)) begin
            hx_d.byte_v   = {rx_q.shin, link.sdi};
            hx_d.was_addr = sel_cfg & ~rx_q.phase;
            hx_d.is_cfg   = sel_cfg;
            hx_d.tgl      = ~hx_q.tgl;
        end
    end

    always_ff @(posedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rx_q <= '0;
        end else begin
            rx_q <= rx_d;
        end
    end

    // the hand-over word outlives the frame, so only the core reset clears it
    always_ff @(posedge link.sck or negedge rst_n) begin
        if (!rst_n) begin
            hx_q <= '0;
        end else begin
            hx_q <= hx_d;
        end
    end

    // ****************************************************************
    // link side: transmit on falling edge
    // ****************************************************************
    always_comb begin
        tx_d         = tx_q;
        tx_d.started = 1'b1;
        if (rx_q.cnt == 3'h0) begin
            tx_d.bit_v = src[7];
            tx_d.sh    = src[6:0];
        end else if (!tx_q.started) begin
            tx_d.bit_v = src[6];
            tx_d.sh    = {src[5:0], 1'b0};
        end else begin
            tx_d.bit_v = tx_q.sh[6];
            tx_d.sh    = {tx_q.sh[5:0], 1'b0};
        end
    end

    always_ff @(negedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx_q <= '0;
        end else begin
            tx_q <= tx_d;
        end
    end

    // first bit must stand before any clock edge, so it comes from the source byte
    assign link.sdo_o  = tx_q.started ? tx_q.bit_v : src[7];
    assign link.sdo_oe = sel_cfg | sel_dat;

    // ****************************************************************
    // core side: registers, fifo and serializer
    // ****************************************************************
    logic        new_byte;
    logic        cfg_rise;
    logic        dat_rise;
    logic        host_push;
    logic        host_pop;
    logic        ser_push;
    logic        ser_pop;
    logic        push;
    logic        pop;
    logic        tick;
    logic [7:0]  ser_byte;
    logic [7:0]  push_data;
    logic [15:0] tick_reload;

    always_comb begin
        c_d       = c_q;
        host_push = 1'b0;
        host_pop  = 1'b0;
        ser_push  = 1'b0;
        ser_pop   = 1'b0;
        ser_byte  = 8'h00;
        c_d.s_cfg = {c_q.s_cfg[1:0], link.config_select_n};
        c_d.s_dat = {c_q.s_dat[1:0], link.data_select_n};
        c_d.s_tgl = {c_q.s_tgl[1:0], hx_q.tgl};
        c_d.s_ctx = {c_q.s_ctx[0], cont_tx_bit};
        new_byte  = c_q.s_tgl[2] ^ c_q.s_tgl[1];
        cfg_rise  = c_q.s_cfg[1] & ~c_q.s_cfg[2];
        dat_rise  = c_q.s_dat[1] & ~c_q.s_dat[2];

        // staged values land together when the config select is released
        if (cfg_rise) begin
            for (int i = 0; i < dss_pkg::NUM_REGS; i++) begin
                if (c_q.smask[i]) begin
                    c_d.cfg[i] = c_q.stage[i];
                end
            end
            c_d.smask = '0;
        end
        if (dat_rise && c_q.pend_v) begin
            host_push  = ~rx_mode;
            c_d.pend_v = 1'b0;
        end
        // new bytes are applied after the commit and push, so they are never lost
        if (new_byte) begin
            if (hx_q.is_cfg) begin
                if (hx_q.was_addr) begin
                    c_d.waddr = hx_q.byte_v[4:0];
                    c_d.wen   = ~hx_q.byte_v[dss_pkg::ACC_RD_BIT];
                end else if (c_q.wen) begin
                    c_d.stage[c_q.waddr] = hx_q.byte_v;
                    c_d.smask[c_q.waddr] = 1'b1;
                end
            end else if (rx_mode) begin
                host_pop = 1'b1;
            end else begin
                c_d.pend   = hx_q.byte_v;
                c_d.pend_v = 1'b1;
            end
        end

        // bit-rate tick
        tick_reload = 16'((({8'h00, c_q.cfg[dss_pkg::REG_BIT_RATE]} + 16'h1) * 16'(BIT_BASE)) - 16'h1);
        tick        = c_q.tick_cnt == 16'h0;
        c_d.tick_cnt = tick ? tick_reload : c_q.tick_cnt - 16'h1;

        if (!data_on) begin
            c_d.ser_n   = 3'h0;
            c_d.mod_bit = c_q.s_ctx[1];
            c_d.cont_rx = demod_bit;
        end else if (tx_mode) begin
            if (tick) begin
                if (c_q.ser_n == 3'h0) begin
                    if (!c_q.empty) begin
                        c_d.mod_bit = head[7];
                        c_d.ser_sh  = {head[6:0], 1'b0};
                        c_d.ser_n   = 3'h7;
                        ser_pop     = 1'b1;
                    end
                end else begin
                    c_d.mod_bit = c_q.ser_sh[7];
                    c_d.ser_sh  = {c_q.ser_sh[6:0], 1'b0};
                    c_d.ser_n   = c_q.ser_n - 3'h1;
                end
            end
        end else if (rx_mode) begin
            if (demod_valid) begin
                c_d.ser_sh = {c_q.ser_sh[6:0], demod_bit};
                c_d.ser_n  = c_q.ser_n + 3'h1;
                if (c_q.ser_n == 3'h7) begin
                    ser_push = 1'b1;
                    ser_byte = {c_q.ser_sh[6:0], demod_bit};
                end
            end
        end else begin
            c_d.ser_n = 3'h0;
        end

        // byte-wide fifo, one push and one pop source per direction
        push      = (rx_mode ? ser_push : host_push) & ~c_q.full;
        pop       = (rx_mode ? host_pop : ser_pop) & ~c_q.empty;
        push_data = rx_mode ? ser_byte : c_q.pend;
        if (push) begin
            c_d.mem[c_q.wp] = push_data;
            c_d.wp          = c_q.wp + AW'(1);
        end
        if (pop) begin
            c_d.rp = c_q.rp + AW'(1);
        end
        c_d.level = c_q.level + (AW+1)'(push) - (AW+1)'(pop);
        c_d.empty = c_d.level == (AW+1)'(0);
        c_d.full  = c_d.level == (AW+1)'(FIFO_DEPTH);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            c_q <= CORE_RST;
        end else begin
            c_q <= c_d;
        end
    end

    assign mod_bit     = c_q.mod_bit;
    assign cont_rx_bit = c_q.cont_rx;
    assign fifo_level  = c_q.level;
    assign fifo_empty  = c_q.empty;
    assign fifo_full   = c_q.full;

endmodule : dss_dev_end

// File: src/dss_pkg.sv
// shared constants and types for the dual-select serial fifo port
package dss_pkg;

    // ****************************************************************
    // clocking and link rates
    // ****************************************************************
    localparam int MCLK_HZ        = 100_000_000;
    localparam int SCK_CFG_MAX_HZ = 6_000_000;
    localparam int SCK_DAT_MAX_HZ = 1_000_000;
    // a least half period rounds up, so the divided clock stays under the limit
    localparam int HALF_CFG_CYC   = (MCLK_HZ + 2 * SCK_CFG_MAX_HZ - 1) / (2 * SCK_CFG_MAX_HZ);
    localparam int HALF_DAT_CYC   = (MCLK_HZ + 2 * SCK_DAT_MAX_HZ - 1) / (2 * SCK_DAT_MAX_HZ);
    localparam int GAP_CYC        = 8;
    localparam int BIT_BASE_CYC   = 16;

    // ****************************************************************
    // configuration access byte and register layout
    // ****************************************************************
    localparam int          BYTE_BITS      = 8;
    localparam int          NUM_REGS       = 32;
    localparam int          ADDR_W         = 5;
    localparam int          ACC_RD_BIT     = 7;
    localparam logic [4:0]  REG_CHIP_MODE  = 5'h00;
    localparam int          CHIP_MODE_LSB  = 5;
    localparam logic [2:0]  CM_RX          = 3'h3;
    localparam logic [2:0]  CM_TX          = 3'h4;
    localparam logic [4:0]  REG_DATA_MODE  = 5'h01;
    localparam int          DATA_MODE_LSB  = 2;
    localparam logic [1:0]  DM_CONT        = 2'h0;
    localparam logic [4:0]  REG_BIT_RATE   = 5'h03;
    localparam logic [7:0]  CHIP_MODE_RST  = 8'h20;
    localparam logic [7:0]  DATA_MODE_RST  = 8'h04;
    localparam logic [7:0]  OTHER_RST      = 8'h00;

    typedef logic [NUM_REGS-1:0][BYTE_BITS-1:0] dss_regs_t;

    function automatic dss_regs_t dss_cfg_reset();
        dss_regs_t r;
        for (int i = 0; i < NUM_REGS; i++) begin
            r[i] = OTHER_RST;
        end
        r[REG_CHIP_MODE] = CHIP_MODE_RST;
        r[REG_DATA_MODE] = DATA_MODE_RST;
        return r;
    endfunction : dss_cfg_reset

    // ****************************************************************
    // host command kinds
    // ****************************************************************
    typedef enum logic [1:0] {
        ACC_CFG_WR,
        ACC_CFG_RD,
        ACC_FIFO_WR,
        ACC_FIFO_RD
    } dss_acc_t;

endpackage : dss_pkg

// File: src/dss_link_if.sv
// serial link between the host end and the device end
`timescale 1ns/100ps
interface dss_link_if;
    logic sck;
    logic config_select_n;
    logic data_select_n;
    logic sdi;
    logic sdo_o;
    logic sdo_oe;
    logic sdo;
    logic sdo_held;

    // bus keeper: the line keeps its last driven level while released
    always_latch begin
        if (sdo_oe) begin
            sdo_held = sdo_o;
        end
    end
    assign sdo = sdo_oe ? sdo_o : sdo_held;

    modport dev  (input sck, input config_select_n, input data_select_n, input sdi, output sdo_o, output sdo_oe);
    modport host (output sck, output config_select_n, output data_select_n, output sdi, input sdo);
endinterface : dss_link_if

// File: src/dss_host_end.sv
// host end: serial master that makes the link clock and runs one access per command
`timescale 1ns/100ps
module dss_host_end (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // serial link
    dss_link_if.host               link,
    // command
    input  wire logic              cmd_valid,
    input  wire dss_pkg::dss_acc_t cmd_kind,
    input  wire logic [4:0]        cmd_addr,
    input  wire logic [7:0]        cmd_wdata,
    output logic                   cmd_ready,
    // answer
    output logic                   rsp_valid,
    output logic [7:0]             rsp_rdata
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP} dss_hst_t;

    typedef struct packed {
        dss_hst_t   st;
        logic [7:0] cnt;
        logic [7:0] half;
        logic [2:0] bitn;
        logic       second;
        logic [7:0] tx;
        logic [7:0] b1;
        logic [7:0] rx;
        logic [1:0] s_sdo;
        logic       sck;
        logic       cfg_n;
        logic       dat_n;
        logic       sdi;
        logic       rdy;
        logic       rsp_v;
        logic [7:0] rsp_d;
    } dss_host_t;

    localparam dss_host_t HOST_RST = '{st: HS_IDLE, cfg_n: 1'b1, dat_n: 1'b1, rdy: 1'b1, default: '0};

    dss_host_t h_q, h_d;
    logic      is_cfg;
    logic [7:0] first;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        h_d       = h_q;
        h_d.s_sdo = {h_q.s_sdo[0], link.sdo};
        h_d.rsp_v = 1'b0;
        is_cfg    = cmd_kind == dss_pkg::ACC_CFG_WR || cmd_kind == dss_pkg::ACC_CFG_RD;
        first     = is_cfg ? {cmd_kind == dss_pkg::ACC_CFG_RD, 2'b00, cmd_addr} : cmd_wdata;
        unique case (h_q.st)
            HS_IDLE: begin
                if (cmd_valid) begin
                    h_d.rdy    = 1'b0;
                    h_d.half   = is_cfg ? 8'(dss_pkg::HALF_CFG_CYC - 1) : 8'(dss_pkg::HALF_DAT_CYC - 1);
                    h_d.cnt    = h_d.half;
                    h_d.tx     = (cmd_kind == dss_pkg::ACC_FIFO_RD) ? 8'h00 : first;
                    h_d.sdi    = h_d.tx[7];
                    h_d.b1     = (cmd_kind == dss_pkg::ACC_CFG_WR) ? cmd_wdata : 8'h00;
                    h_d.second = is_cfg;
                    h_d.bitn   = 3'h0;
                    h_d.cfg_n  = ~is_cfg;
                    h_d.dat_n  = is_cfg;
                    h_d.st     = HS_LOW;
                end
            end
            HS_LOW: begin
                if (h_q.cnt == 8'h00) begin
                    h_d.sck = 1'b1;
                    h_d.rx  = {h_q.rx[6:0], h_q.s_sdo[1]};
                    h_d.cnt = h_q.half;
                    h_d.st  = HS_HIGH;
                end else begin
                    h_d.cnt = h_q.cnt - 8'h01;
                end
            end
            HS_HIGH: begin
                if (h_q.cnt == 8'h00) begin
                    h_d.sck = 1'b0;
                    h_d.cnt = h_q.half;
                    if (h_q.bitn == 3'h7) begin
                        h_d.bitn = 3'h0;
                        if (h_q.second) begin
                            h_d.second = 1'b0;
                            h_d.tx     = h_q.b1;
                            h_d.sdi    = h_q.b1[7];
                            h_d.st     = HS_LOW;
                        end else begin
                            h_d.st = HS_TAIL;
                        end
                    end else begin
                        h_d.bitn = h_q.bitn + 3'h1;
                        h_d.sdi  = h_q.tx[6];
                        h_d.tx   = {h_q.tx[6:0], 1'b0};
                        h_d.st   = HS_LOW;
                    end
                end else begin
                    h_d.cnt = h_q.cnt - 8'h01;
                end
            end
            HS_TAIL: begin
                if (h_q.cnt == 8'h00) begin
                    // every fifo byte ends with a select release, writes and reads alike
                    h_d.cfg_n = 1'b1;
                    h_d.dat_n = 1'b1;
                    h_d.rsp_v = 1'b1;
                    h_d.rsp_d = h_q.rx;
                    h_d.cnt   = 8'(dss_pkg::GAP_CYC - 1);
                    h_d.st    = HS_GAP;
                end else begin
                    h_d.cnt = h_q.cnt - 8'h01;
                end
            end
            HS_GAP: begin
                if (h_q.cnt == 8'h00) begin
                    h_d.rdy = 1'b1;
                    h_d.st  = HS_IDLE;
                end else begin
                    h_d.cnt = h_q.cnt - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            h_q <= HOST_RST;
        end else begin
            h_q <= h_d;
        end
    end

    assign link.sck             = h_q.sck;
    assign link.config_select_n = h_q.cfg_n;
    assign link.data_select_n   = h_q.dat_n;
    assign link.sdi             = h_q.sdi;
    assign cmd_ready            = h_q.rdy;
    assign rsp_valid            = h_q.rsp_v;
    assign rsp_rdata            = h_q.rsp_d;

endmodule : dss_host_end

// File: dv/dss_chk.sv
// link checker for the dual-select serial fifo port
`timescale 1ns/100ps
module dss_chk (
    // clock and reset
    input logic mclk,
    input logic rst_n,
    // link
    input logic sck,
    input logic config_select_n,
    input logic data_select_n,
    input logic sdo_o,
    input logic sdo_oe,
    input logic sdo
);
    // ****
    // helper counters: sck high time, rising sck per frame
    // ****
    logic [7:0] hi_q;
    logic [7:0] rc_q;
    logic       sck_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_q  <= 8'h00;
            rc_q  <= 8'h00;
            sck_q <= 1'b0;
        end else begin
            hi_q  <= sck ? hi_q + 8'h01 : 8'h00;
            rc_q  <= (config_select_n && data_select_n) ? 8'h00 : rc_q + {7'h00, sck && !sck_q};
            sck_q <= sck;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_cfg_high;
        sck [*8] ##1 !sck;
    endsequence
    a_cfg_wins: assert property (!config_select_n |-> sdo_oe) else $error("sdo idle in config frame");
    a_sdo_release: assert property (config_select_n && data_select_n |-> !sdo_oe) else $error("sdo driven");
    a_keeper_hold: assert property ($fell(sdo_oe) |-> sdo == $past(sdo_o)) else $error("sdo lost level");
    a_sdo_on_fall: assert property (sdo_oe && $past(sdo_oe) && !config_select_n && $changed(sdo_o)
        |-> $fell(sck)) else $error("sdo moved off falling sck");
    a_sck_idle: assert property (config_select_n && data_select_n |-> !sck) else $error("sck not idle low");
    a_cfg_rate: assert property ($rose(sck) && !config_select_n |=> s_cfg_high) else $error("config sck fast");
    a_dat_rate: assert property ($fell(sck) && !data_select_n && config_select_n |-> hi_q == 8'd50)
        else $error("data sck wrong");
    a_dat_bytes: assert property ($rose(data_select_n) && config_select_n |-> rc_q == 8'd8)
        else $error("data frame not one byte");
    a_cfg_bytes: assert property ($rose(config_select_n) |-> rc_q == 8'd16) else $error("config frame length");
endmodule : dss_chk

// File: dv/tb_dual_select_spi_fifo_port.sv
// self-checking bench: host end drives the device end across the link
`timescale 1ns/100ps
module tb_dual_select_spi_fifo_port;
    logic mclk, rst_n, cmd_valid, cmd_ready, rsp_valid, demod_bit, demod_valid, cont_tx_bit;
    logic cont_rx_bit, mod_bit, fifo_empty, fifo_full;
    dss_pkg::dss_acc_t cmd_kind;
    logic [4:0] cmd_addr;
    logic [7:0] cmd_wdata, rsp_rdata, wsh, v;
    logic [6:0] fifo_level;
    logic [8:0] rq[$];
    logic [8:0] wq[$];
    logic [8:0] e, f;
    logic [7:0] msh, mq[$];
    logic [6:0] lv_q;
    logic [3:0] mn = 4'h0;
    logic       tx_on = 1'b0;
    int         fails, checks, cyc;
    integer     seed = 32'hd18e;
    dss_link_if lnk ();
    dss_host_end dss_host_end_inst (.mclk(mclk), .rst_n(rst_n), .link(lnk.host), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    dss_dev_end #(.BIT_BASE(1)) dss_dev_end_inst (.mclk(mclk), .rst_n(rst_n), .link(lnk.dev),
        .cont_tx_bit(cont_tx_bit), .cont_rx_bit(cont_rx_bit), .demod_bit(demod_bit), .demod_valid(demod_valid),
        .mod_bit(mod_bit), .fifo_level(fifo_level), .fifo_empty(fifo_empty), .fifo_full(fifo_full));
    dss_chk dss_chk_inst (.mclk(mclk), .rst_n(rst_n), .sck(lnk.sck), .config_select_n(lnk.config_select_n),
        .data_select_n(lnk.data_select_n), .sdo_o(lnk.sdo_o), .sdo_oe(lnk.sdo_oe), .sdo(lnk.sdo));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        checks++;
        if (s !== x) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, s, x);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    // one access; entered just after a rising edge with cmd_ready high
    task automatic cmd(input dss_pkg::dss_acc_t k, input logic [4:0] a, input logic [7:0] d, input logic [8:0] x);
        if (k == dss_pkg::ACC_FIFO_WR || k == dss_pkg::ACC_FIFO_RD)
            wq.push_back({k == dss_pkg::ACC_FIFO_WR, d});
        rq.push_back(x);
        cmd_valid <= 1'b1;
        cmd_kind  <= k;
        cmd_addr  <= a;
        cmd_wdata <= d;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        do @(posedge mclk); while (cmd_ready !== 1'b1);
    endtask : cmd
    // ****
    // watchers: answers and bytes on the wire
    // ****
    always @(posedge mclk) begin
        if (rsp_valid === 1'b1 && rq.size() > 0) begin
            e = rq.pop_front();
            if (e[8]) chk(rsp_rdata, e[7:0]);
        end
    end
    always @(posedge lnk.sck) if (!lnk.data_select_n && lnk.config_select_n) wsh <= {wsh[6:0], lnk.sdi};
    always @(posedge lnk.data_select_n) begin
        if (lnk.config_select_n && wq.size() > 0) begin
            f = wq.pop_front();
            if (f[8]) chk(wsh, f[7:0]);
        end
    end
    // a pop in transmit puts the byte's top bit on mod_bit; collect that sample and the next seven
    always @(posedge mclk) begin
        lv_q <= fifo_level;
        if (mn != 4'h0) begin
            msh = {msh[6:0], mod_bit};
            mn  = mn - 4'h1;
            if (mn == 4'h0) chk(msh, mq.pop_front());
        end else if (tx_on && fifo_level < lv_q) begin
            msh = {7'h00, mod_bit};
            mn  = 4'h7;
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        {cmd_valid, demod_bit, demod_valid, cont_tx_bit, rst_n} = 5'h00;
        cmd_kind = dss_pkg::ACC_CFG_WR;
        cmd_addr = 5'h00;
        cmd_wdata = 8'h00;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        cmd(dss_pkg::ACC_CFG_RD, 5'h00, 8'h00, 9'h120);
        cmd(dss_pkg::ACC_CFG_RD, 5'h01, 8'h00, 9'h104);
        v = 8'($random(seed));
        cmd(dss_pkg::ACC_CFG_WR, 5'h05, v, 9'h000);
        cmd(dss_pkg::ACC_CFG_RD, 5'h05, 8'h00, {1'b1, v});
        cmd(dss_pkg::ACC_CFG_WR, 5'h00, 8'h00, 9'h000);
        cmd(dss_pkg::ACC_CFG_RD, 5'h05, 8'h00, {1'b1, v});
        $display("test config done");
        for (int i = 0; i < 2; i++) begin
            v = 8'($random(seed));
            mq.push_back(v);
            cmd(dss_pkg::ACC_FIFO_WR, 5'h00, v, 9'h000);
        end
        chk({1'b0, fifo_level}, 8'h02);
        cmd(dss_pkg::ACC_CFG_WR, 5'h03, 8'h00, 9'h000);
        tx_on = 1'b1;
        cmd(dss_pkg::ACC_CFG_WR, 5'h00, 8'h80, 9'h000);
        for (int i = 0; i < 400 && fifo_empty !== 1'b1; i++) @(posedge mclk);
        chk({7'h00, fifo_empty}, 8'h01);
        repeat (10) @(posedge mclk);
        chk(8'(mq.size()), 8'h00);
        tx_on = 1'b0;
        $display("test transmit done");
        cmd(dss_pkg::ACC_CFG_WR, 5'h00, 8'h60, 9'h000);
        v = 8'($random(seed));
        // sixty-four copies of the byte fill the fifo to the brim
        for (int i = 511; i >= 0; i--) begin
            demod_bit   <= v[i % 8];
            demod_valid <= 1'b1;
            @(posedge mclk);
            demod_valid <= 1'b0;
            @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
        chk({fifo_full, fifo_level}, 8'hc0);
        cmd(dss_pkg::ACC_FIFO_RD, 5'h00, 8'h00, {1'b1, v});
        chk({fifo_full, fifo_level}, 8'h3f);
        $display("test receive done");
        cmd(dss_pkg::ACC_CFG_WR, 5'h00, 8'h20, 9'h000);
        cmd(dss_pkg::ACC_CFG_WR, 5'h01, 8'h00, 9'h000);
        cmd(dss_pkg::ACC_FIFO_WR, 5'h00, 8'ha5, 9'h000);
        chk({1'b0, fifo_level}, 8'h3f);
        cont_tx_bit <= 1'b0;
        demod_bit   <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({6'h00, mod_bit, cont_rx_bit}, 8'h01);
        cont_tx_bit <= 1'b1;
        demod_bit   <= 1'b0;
        repeat (4) @(posedge mclk);
        chk({6'h00, mod_bit, cont_rx_bit}, 8'h02);
        $display("test continuous done");
        finish_test();
    end
endmodule : tb_dual_select_spi_fifo_port
